// >>> core/au_pkg.sv
// Constants and types shared by the arithmetic unit files
package au_pkg;
	// Bus geometry
	localparam int AU_DATA_W = 32;
	localparam int AU_ADDR_W = 8;
	localparam int AU_NUM_DATA = 6;
	// Byte offsets of the registers
	localparam logic [7:0] AU_OFF_DATA0 = 8'h00;
	localparam logic [7:0] AU_OFF_STATUS = 8'h18;
	// Data register indices used by the write orderings
	localparam logic [2:0] AU_IDX_0 = 3'h0;
	localparam logic [2:0] AU_IDX_1 = 3'h1;
	localparam logic [2:0] AU_IDX_2 = 3'h2;
	localparam logic [2:0] AU_IDX_3 = 3'h3;
	localparam logic [2:0] AU_IDX_4 = 3'h4;
	localparam logic [2:0] AU_IDX_5 = 3'h5;
	// Status fields and reset values
	localparam int AU_ERR_BIT = 7;
	localparam int AU_OVF_BIT = 6;
	localparam logic [7:0] AU_STATUS_RST = 8'h00;
	localparam logic [7:0] AU_DATA_RST = 8'h00;
	localparam logic [31:0] AU_PROD_LIMIT = 32'h0000FFFF;
	// Calculation times in system clock periods
	localparam int AU_DIV32_SYSTEM_CLOCK_PERIOD = 17;
	localparam int AU_DIV16_SYSTEM_CLOCK_PERIOD = 9;
	localparam int AU_MUL_SYSTEM_CLOCK_PERIOD = 11;
	localparam int AU_SYS_PERIOD_PS = 8000;
	localparam int AU_CLK_PERIOD_PS = 8000;
	localparam logic [4:0] AU_DIV32_CYC = 5'(AU_DIV32_SYSTEM_CLOCK_PERIOD * AU_SYS_PERIOD_PS / AU_CLK_PERIOD_PS);
	localparam logic [4:0] AU_DIV16_CYC = 5'(AU_DIV16_SYSTEM_CLOCK_PERIOD * AU_SYS_PERIOD_PS / AU_CLK_PERIOD_PS);
	localparam logic [4:0] AU_MUL_CYC = 5'(AU_MUL_SYSTEM_CLOCK_PERIOD * AU_SYS_PERIOD_PS / AU_CLK_PERIOD_PS);
	localparam logic [4:0] AU_CNT_IDLE = 5'h00;
	localparam logic [4:0] AU_CNT_LAST = 5'h01;
	// Operation selected by the write ordering
	typedef enum logic [2:0] {
		AU_OP_DIV32 = 3'h1,
		AU_OP_DIV16 = 3'h2,
		AU_OP_MUL = 3'h4
	} au_op_type;
	// Progress through the write orderings
	typedef enum logic [8:0] {
		AU_SEQ_NONE = 9'h001,
		AU_SEQ_0 = 9'h002,
		AU_SEQ_01 = 9'h004,
		AU_SEQ_012 = 9'h008,
		AU_SEQ_0123 = 9'h010,
		AU_SEQ_01234 = 9'h020,
		AU_SEQ_014 = 9'h040,
		AU_SEQ_04 = 9'h080,
		AU_SEQ_041 = 9'h100
	} au_seq_type;
	// State of the calculation engine
	typedef struct packed {
		logic [4:0] cnt;
		au_op_type op;
		logic [15:0] rem;
		logic [31:0] quo;
		logic [15:0] dsr;
		logic [31:0] prod;
	} au_eng_state_type;
	// State of the register block
	typedef struct packed {
		logic [5:0][7:0] data;
		au_seq_type seq;
		logic err;
		logic ovf;
		logic [31:0] rdata;
	} au_top_state_type;
endpackage : au_pkg

// >>> core/au_engine.sv
// Calculation engine: two-bit-per-cycle divider and multiplier with fixed latency
`timescale 1ns/1ps
module au_engine
	import au_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire au_op_type op_in,
	input wire logic [31:0] opa_in,
	input wire logic [15:0] opb_in,
	output logic busy_out,
	output logic done_out,
	output au_op_type op_out,
	output logic [31:0] quo_out,
	output logic [15:0] rem_out,
	output logic [31:0] prod_out,
	output logic ovf_out
);
	au_eng_state_type s_r;
	au_eng_state_type s_nxt;

	// One restoring division step
	function automatic logic [47:0] div_step(input logic [15:0] r, input logic [31:0] q,
		input logic [15:0] d);
		logic [16:0] t;
		logic [31:0] qq;
		t = {r, q[31]};
		qq = {q[30:0], 1'b0};
		if (t >= {1'b0, d}) begin
			t = t - {1'b0, d};
			qq[0] = 1'b1;
		end
		return {t[15:0], qq};
	endfunction : div_step

	// Load on start, then count down; division shifts two bits per cycle
	always_comb begin
		logic [47:0] st;
		st = '0;
		s_nxt = s_r;
		if (start_in) begin
			s_nxt.op = op_in;
			s_nxt.rem = 16'h0000;
			s_nxt.dsr = opb_in;
			s_nxt.prod = opa_in[15:0] * opb_in;
			if (op_in == AU_OP_DIV32) begin
				s_nxt.cnt = AU_DIV32_CYC;
				s_nxt.quo = opa_in;
			end else if (op_in == AU_OP_DIV16) begin
				s_nxt.cnt = AU_DIV16_CYC;
				s_nxt.quo = {opa_in[15:0], 16'h0000};
			end else begin
				s_nxt.cnt = AU_MUL_CYC;
				s_nxt.quo = 32'h00000000;
			end
		end else if (s_r.cnt != AU_CNT_IDLE) begin
			s_nxt.cnt = s_r.cnt - AU_CNT_LAST;
			if (s_r.cnt > AU_CNT_LAST && s_r.op != AU_OP_MUL) begin
				st = div_step(s_r.rem, s_r.quo, s_r.dsr);
				st = div_step(st[47:32], st[31:0], s_r.dsr);
				s_nxt.rem = st[47:32];
				s_nxt.quo = st[31:0];
			end
		end
	end

	// State register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r <= '{cnt: AU_CNT_IDLE, op: AU_OP_DIV32, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Results and flags
	assign busy_out = (s_r.cnt != AU_CNT_IDLE);
	assign done_out = (s_r.cnt == AU_CNT_LAST);
	assign op_out = s_r.op;
	assign quo_out = s_r.quo;
	assign rem_out = s_r.rem;
	assign prod_out = s_r.prod;
	assign ovf_out = (s_r.op == AU_OP_MUL) ? (s_r.prod > AU_PROD_LIMIT) : (s_r.dsr == 16'h0000);
endmodule : au_engine

// >>> core/au_top.sv
// Arithmetic unit: byte registers on APB, write-order decoding and result storage
`timescale 1ns/1ps
module au_top
	import au_pkg::*;
#(
	parameter int ADDR_W = AU_ADDR_W
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	output logic BUSY_OUT
);
	// Registered state and its next value
	au_top_state_type s_r;
	au_top_state_type s_nxt;

	// Bus phase decode
	logic setup_ph;
	logic access_ph;
	logic wr_acc;
	logic rd_acc;

	// Address decode results
	logic hit_data;
	logic hit_status;
	logic mapped;
	logic [2:0] idx;

	// Sequence tracking
	au_seq_type seq_adv;
	logic seq_match;
	au_op_type seq_op;

	// Engine interface
	logic eng_start;
	logic eng_busy;
	logic eng_done;
	au_op_type eng_op;
	logic [31:0] eng_quo;
	logic [15:0] eng_rem;
	logic [31:0] eng_prod;
	logic eng_ovf;
	logic [31:0] opa;
	logic [15:0] opb;

	// Status byte as seen by software
	logic [7:0] status_val;

	// Next step of the write ordering after a write to register idx
	function automatic au_seq_type seq_step(input au_seq_type cur, input logic [2:0] i);
		au_seq_type nx;
		nx = AU_SEQ_NONE;
		if (i == AU_IDX_0) begin
			nx = AU_SEQ_0; // Any write to register 0 begins afresh
		end else begin
			case (cur)
				AU_SEQ_0: begin
					if (i == AU_IDX_1) begin
						nx = AU_SEQ_01;
					end else if (i == AU_IDX_4) begin
						nx = AU_SEQ_04;
					end
				end
				AU_SEQ_01: begin
					if (i == AU_IDX_2) begin
						nx = AU_SEQ_012;
					end else if (i == AU_IDX_4) begin
						nx = AU_SEQ_014;
					end
				end
				AU_SEQ_012: begin
					if (i == AU_IDX_3) begin
						nx = AU_SEQ_0123;
					end
				end
				AU_SEQ_0123: begin
					if (i == AU_IDX_4) begin
						nx = AU_SEQ_01234;
					end
				end
				AU_SEQ_04: begin
					if (i == AU_IDX_1) begin
						nx = AU_SEQ_041;
					end
				end
				default: begin
					nx = AU_SEQ_NONE;
				end
			endcase
		end
		return nx;
	endfunction : seq_step

	// APB phases; the slave never inserts wait states
	assign setup_ph = PSEL_IN & ~PENABLE_IN;
	assign access_ph = PSEL_IN & PENABLE_IN;
	assign wr_acc = access_ph & PWRITE_IN;
	assign rd_acc = access_ph & ~PWRITE_IN;

	// Address decode: six data words, then the status word
	always_comb begin
		hit_data = 1'b0;
		hit_status = 1'b0;
		idx = PADDR_IN[4:2];
		if (PADDR_IN[1:0] != 2'b00) begin
			hit_data = 1'b0; // Unaligned addresses are not mapped
		end else if (PADDR_IN[ADDR_W-1:2] < (ADDR_W - 2)'(AU_NUM_DATA)) begin
			hit_data = 1'b1;
		end else if (PADDR_IN == ADDR_W'(AU_OFF_STATUS)) begin
			hit_status = 1'b1;
		end
		mapped = hit_data | hit_status;
	end

	// Status byte, low bits fixed at zero
	always_comb begin
		status_val = AU_STATUS_RST;
		status_val[AU_ERR_BIT] = s_r.err;
		status_val[AU_OVF_BIT] = s_r.ovf;
	end

	// Does this write to register 5 finish a known ordering
	always_comb begin
		seq_match = 1'b0;
		seq_op = AU_OP_DIV32;
		case (s_r.seq)
			AU_SEQ_01234: begin
				seq_match = 1'b1;
				seq_op = AU_OP_DIV32;
			end
			AU_SEQ_014: begin
				seq_match = 1'b1;
				seq_op = AU_OP_DIV16;
			end
			AU_SEQ_041: begin
				seq_match = 1'b1;
				seq_op = AU_OP_MUL;
			end
			default: begin
				seq_match = 1'b0;
				seq_op = AU_OP_DIV32;
			end
		endcase
	end

	// Next ordering state for the current write
	assign seq_adv = seq_step(s_r.seq, idx);

	// Start only on an idle register 5 write that closes an ordering
	assign eng_start = wr_acc & hit_data & ~eng_busy & (idx == AU_IDX_5) & seq_match;

	// Operands: register 5 byte comes straight from the bus; low bytes first
	assign opa = {s_r.data[3], s_r.data[2], s_r.data[1], s_r.data[0]};
	assign opb = {PWDATA_IN[7:0], s_r.data[4]};

	// Calculation engine
	au_engine u_engine (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.start_in(eng_start),
		.op_in(seq_op),
		.opa_in(opa),
		.opb_in(opb),
		.busy_out(eng_busy),
		.done_out(eng_done),
		.op_out(eng_op),
		.quo_out(eng_quo),
		.rem_out(eng_rem),
		.prod_out(eng_prod),
		.ovf_out(eng_ovf)
	);

	// Register block next-state logic
	always_comb begin
		s_nxt = s_r;

		// Read data is fetched in the setup cycle and held for the access phase
		if (setup_ph && !PWRITE_IN) begin
			if (hit_data) begin
				s_nxt.rdata = {24'h000000, s_r.data[idx]};
			end else if (hit_status) begin
				s_nxt.rdata = {24'h000000, status_val};
			end else begin
				s_nxt.rdata = 32'h00000000;
			end
		end

		// Writes to the data registers while idle load bytes and steer the ordering
		if (wr_acc && hit_data && !eng_busy) begin
			s_nxt.data[idx] = PWDATA_IN[7:0];
			if (idx == AU_IDX_5) begin
				s_nxt.seq = AU_SEQ_NONE; // Started or stray, begin again
			end else begin
				s_nxt.seq = seq_adv;
			end
		end

		// Completion stores results in their read order
		if (eng_done) begin
			s_nxt.ovf = eng_ovf;
			if (eng_op == AU_OP_DIV32) begin
				s_nxt.data[0] = eng_quo[7:0];
				s_nxt.data[1] = eng_quo[15:8];
				s_nxt.data[2] = eng_quo[23:16];
				s_nxt.data[3] = eng_quo[31:24];
				s_nxt.data[4] = eng_rem[7:0];
				s_nxt.data[5] = eng_rem[15:8];
			end else if (eng_op == AU_OP_DIV16) begin
				s_nxt.data[0] = eng_quo[7:0];
				s_nxt.data[1] = eng_quo[15:8];
				s_nxt.data[4] = eng_rem[7:0];
				s_nxt.data[5] = eng_rem[15:8];
			end else begin
				s_nxt.data[0] = eng_prod[7:0];
				s_nxt.data[1] = eng_prod[15:8];
				s_nxt.data[2] = eng_prod[23:16];
				s_nxt.data[3] = eng_prod[31:24];
			end
		end

		// Error clear on an idle status read; a new error wins over the clear
		if (rd_acc && hit_status && !eng_busy && s_r.err) begin
			s_nxt.err = 1'b0;
		end
		if (access_ph && hit_data && eng_busy) begin
			s_nxt.err = 1'b1;
		end
	end

	// State register
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			s_r <= '{
				data: {AU_NUM_DATA{AU_DATA_RST}},
				seq: AU_SEQ_NONE,
				err: AU_STATUS_RST[AU_ERR_BIT],
				ovf: AU_STATUS_RST[AU_OVF_BIT],
				rdata: 32'h00000000
			};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Bus answers: no wait states, error for unmapped words
	assign PRDATA_OUT = s_r.rdata;
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = access_ph & ~mapped;
	assign BUSY_OUT = eng_busy;
endmodule : au_top

// >>> dv/au_top_monitor.sv
// Port checker for the arithmetic unit
`timescale 1ns/1ps
module au_top_monitor
	import au_pkg::*;
#(
	parameter int ADDR_W = AU_ADDR_W
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic BUSY_OUT
);
	typedef struct packed {
		logic [4:0] cnt;
		logic err;
	} au_mon_type;
	au_mon_type st_r;
	au_mon_type st_nxt;
	logic acc;
	logic dat;
	logic srd;
	// Access edge, data register and status read decodes
	assign acc = PSEL_IN && PENABLE_IN;
	assign dat = PADDR_IN < 8'h18 && PADDR_IN[1:0] == 2'h0;
	assign srd = acc && !PWRITE_IN && PADDR_IN == 8'h18;
	// Busy length and expected error flag
	always_comb begin
		st_nxt = st_r;
		st_nxt.cnt = BUSY_OUT ? st_r.cnt + 5'h01 : 5'h00;
		if (acc && dat && BUSY_OUT) begin
			st_nxt.err = 1'b1;
		end else if (srd && !BUSY_OUT) begin
			st_nxt.err = 1'b0;
		end
	end
	// Helper registers
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	chk_busy_start: assert property ($rose(BUSY_OUT) |-> $past(acc && PWRITE_IN && PADDR_IN == 8'h14))
		else $error("busy rose without a register 5 write");
	chk_busy_hold: assert property ($rose(BUSY_OUT) |-> BUSY_OUT [*8])
		else $error("busy too short");
	chk_busy_len: assert property ($fell(BUSY_OUT) |-> st_r.cnt inside {5'h11, 5'h09, 5'h0B})
		else $error("busy length wrong");
	chk_err_flag: assert property (srd |-> PRDATA_OUT[7] == st_r.err)
		else $error("error flag wrong");
	chk_stat_zero: assert property (srd |-> PRDATA_OUT[5:0] == 6'h00 && PRDATA_OUT[31:8] == 24'h000000)
		else $error("status spare bits set");
	chk_data_byte: assert property (acc && !PWRITE_IN && dat |-> PRDATA_OUT[31:8] == 24'h000000)
		else $error("data read wider than a byte");
	chk_ready_high: assert property (PREADY_OUT)
		else $error("ready low");
	chk_slverr_map: assert property (acc |-> PSLVERR_OUT == (PADDR_IN > 8'h18 || PADDR_IN[1:0] != 2'h0))
		else $error("slave error decode wrong");
endmodule : au_top_monitor
bind au_top au_top_monitor #(.ADDR_W(ADDR_W)) au_top_monitor_inst (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
	.PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
	.PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .BUSY_OUT(BUSY_OUT));

// >>> dv/au_cpu_model.sv
// Bus master model standing in for the processor core
`timescale 1ns/1ps
module au_cpu_model (
	input wire logic clk_in,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in,
	output logic psel_out,
	output logic penable_out,
	output logic pwrite_out,
	output logic [7:0] paddr_out,
	output logic [31:0] pwdata_out
);
	// Idle bus at time zero
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'h00;
		pwdata_out = 32'h00000000;
	end
	// One transfer, held until ready is seen
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk_in);
		psel_out <= 1'b1;
		penable_out <= 1'b0;
		pwrite_out <= wr;
		paddr_out <= a;
		pwdata_out <= {24'h000000, d};
		@(posedge clk_in);
		penable_out <= 1'b1;
		do @(posedge clk_in); while (pready_in !== 1'b1);
		q = prdata_in;
		e = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		// Released lines change so stale values never match
		paddr_out <= ~a;
		pwdata_out <= ~pwdata_out;
	endtask : xfer
endmodule : au_cpu_model

// >>> dv/au_top_bench.sv
// Self-checking bench for the arithmetic unit
`timescale 1ns/1ps
module au_top_bench
	import au_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, busy, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, a, r;
	logic [15:0] b;
	logic [31:0] seed = 32'h0001834D;
	int err_total = 0;
	int tests_run = 0;
	int wl[3][6] = '{'{0, 1, 2, 3, 4, 5}, '{0, 1, 4, 5, 0, 0}, '{0, 4, 1, 5, 0, 0}};
	int rl[3][6] = '{'{0, 1, 2, 3, 4, 5}, '{0, 1, 4, 5, 0, 0}, '{0, 1, 2, 3, 0, 0}};
	int lat[3] = '{AU_DIV32_SYSTEM_CLOCK_PERIOD, AU_DIV16_SYSTEM_CLOCK_PERIOD, AU_MUL_SYSTEM_CLOCK_PERIOD};
	always #4 clk = ~clk;
	au_top au_top_inst (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .BUSY_OUT(busy));
	au_cpu_model au_cpu_model_inst (.clk_in(clk), .prdata_in(prdata), .pready_in(pready),
		.pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
		.paddr_out(paddr), .pwdata_out(pwdata));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Expected overflow, remainder and quotient or product
	function automatic logic [48:0] calc(int k, logic [31:0] x, logic [15:0] y);
		logic [31:0] p;
		p = x[15:0] * y;
		if (k == 2) return {p > 32'h0000FFFF, 16'h0000, p};
		if (y == 16'h0000) return {1'b1, 48'h0};
		return {1'b0, 16'(x % y), x / y};
	endfunction : calc
	task chk(logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(logic [7:0] ad, logic [7:0] d);
		au_cpu_model_inst.xfer(1'b1, ad, d, q, e);
	endtask : wr
	task rd(logic [7:0] ad);
		au_cpu_model_inst.xfer(1'b0, ad, 8'h00, q, e);
	endtask : rd
	task summarize();
		$display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	// One operation: ordered writes, optional access while busy, status, results
	task automatic op(int k, logic [31:0] x, logic [15:0] y, logic inj);
		logic [48:0] v;
		int n;
		v = calc(k, x, y);
		for (int i = 0; i < ((k == 0) ? 6 : 4); i++) begin
			n = wl[k][i];
			wr(8'(4 * n), (n < 4) ? x[8*n+:8] : y[8*(n-4)+:8]);
			if (i == 1) rd(AU_OFF_STATUS);
		end
		if (inj) rd(AU_OFF_DATA0);
		n = 0;
		#1;
		// Nothing else is issued until the calculation has ended
		while (busy === 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (!inj) chk(n, lat[k]);
		rd(AU_OFF_STATUS);
		chk(q, {24'h0, inj, v[48], 6'h00});
		if (inj) begin
			rd(AU_OFF_STATUS);
			chk(q, {24'h0, 1'b0, v[48], 6'h00});
		end
		for (int i = 0; i < ((k == 0) ? 6 : 4) && !v[48]; i++) begin
			n = rl[k][i];
			rd(8'(4 * n));
			chk(q, {24'h0, (n < 4) ? v[8*n+:8] : v[32+8*(n-4)+:8]});
			if (i == 0) wr(AU_OFF_STATUS, 8'hFF);
		end
	endtask : op
	// Watchdog
	initial begin
		#200000;
		err_total++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(AU_OFF_STATUS);
		chk(q, {24'h0, AU_STATUS_RST});
		op(0, 32'hFFFFFFFF, 16'h0001, 1'b0);
		op(1, 32'h00001234, 16'h0000, 1'b0);
		op(2, 32'h0000FFFF, 16'h0001, 1'b0);
		op(2, 32'h00000100, 16'h0100, 1'b0);
		op(0, 32'h89ABCDEF, 16'hFFFF, 1'b1);
		for (int i = 0; i < 30; i++) begin
			a = rnd();
			r = rnd();
			b = 16'(r >> (16 + r[3:0]));
			if (i % 3 > 0) a[31:16] = 16'h0000;
			op(i % 3, a, b, i % 7 == 3);
		end
		// Broken ordering ends in a plain register 5 write
		wr(AU_OFF_DATA0, 8'h5A);
		wr(8'h08, 8'hC3);
		wr(8'h14, 8'h3C);
		#1;
		chk({31'h0, busy}, 32'h0);
		rd(8'h14);
		chk(q, 32'h0000003C);
		rd(8'h1C);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		// Unaligned word is refused as well
		rd(8'h01);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		summarize();
	end
endmodule : au_top_bench
